// *** bench/cdsi_codec_model.sv ***
// Codec model: bit clock, frame sync and data lines of the far side.
`timescale 1ns/1ps
module cdsi_codec_model (
  input wire logic clk_run_i,
  input wire logic sync_drive_i,
  input wire logic [8:0] frame_bits_i,
  input wire logic data_level_i,
  input wire logic bck_dev_i,
  input wire logic bck_oe_i,
  input wire logic fs_dev_i,
  input wire logic fs_oe_i,
  input wire logic sdo_dev_i,
  input wire logic sdo_oe_i,
  output logic bck_o,
  output logic fs_o,
  output logic sdi_o,
  output logic [31:0] last_frame_o,
  output logic [8:0] last_len_o,
  output logic [15:0] frames_o
);
  logic ext_clk_q = 1'b0;
  logic [8:0] gen_cnt_q = 9'h000;
  logic [8:0] len_q = 9'h000;
  logic [31:0] shift_q = 32'h0000_0000;
  logic fs_prev_q = 1'b0;
  logic sdo_line;
  initial begin
    last_frame_o = 32'h0000_0000;
    last_len_o = 9'h000;
    frames_o = 16'h0000;
    #3;
    forever #40 ext_clk_q = clk_run_i ? ~ext_clk_q : 1'b0;
  end
  // The codec drives the clock and sync lines only when it is their master.
  assign bck_o = bck_oe_i ? bck_dev_i : (sync_drive_i ? ext_clk_q : 1'b1);
  assign fs_o = fs_oe_i ? fs_dev_i :
    (sync_drive_i ? (gen_cnt_q == 9'h000) : 1'b1);
  assign sdo_line = sdo_oe_i ? sdo_dev_i : ~shift_q[0];
  assign sdi_o = data_level_i;
  // Data is taken on the rising edge, half a bit after the device launches it.
  always @(posedge bck_o) begin
    if (fs_o && !fs_prev_q) begin
      last_frame_o <= shift_q;
      last_len_o <= len_q;
      frames_o <= frames_o + 16'h0001;
      len_q <= 9'h001;
      shift_q <= {31'h0, sdo_line};
    end else begin
      len_q <= len_q + 9'h001;
      shift_q <= {shift_q[30:0], sdo_line};
    end
    fs_prev_q <= fs_o;
    if (sync_drive_i) begin
      if (gen_cnt_q + 9'h001 == frame_bits_i) begin
        gen_cnt_q <= 9'h000;
      end else begin
        gen_cnt_q <= gen_cnt_q + 9'h001;
      end
    end
  end
endmodule // cdsi_codec_model

// *** bench/codec_serial_interface_bench.sv ***
// Bench for the converter serial module with a codec model.
`timescale 1ns/1ps
module codec_serial_interface_bench;
  logic clk_sys_i;
  logic reset_i;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d, frame;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic bck, bck_o, bck_oe, fs, fs_o, fs_oe, sdi, sdo, sdo_oe;
  logic run, sdrv, lvl;
  logic [8:0] fbits, flen;
  logic [15:0] frames;
  int mismatches = 0;
  int cmp_count = 0;
  int wd = 0;

  cdsi_core i_cdsi_core (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .ce_i(1'b1), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .bit_clock_pin_i(bck),
    .bit_clock_pin_o(bck_o), .bit_clock_pin_oe_o(bck_oe),
    .frame_sync_pin_i(fs), .frame_sync_pin_o(fs_o),
    .frame_sync_pin_oe_o(fs_oe), .serial_data_in_pin_i(sdi),
    .serial_data_out_pin_o(sdo), .serial_data_out_pin_oe_o(sdo_oe));

  cdsi_codec_model i_cdsi_codec_model (.clk_run_i(run),
    .sync_drive_i(sdrv), .frame_bits_i(fbits), .data_level_i(lvl),
    .bck_dev_i(bck_o), .bck_oe_i(bck_oe), .fs_dev_i(fs_o),
    .fs_oe_i(fs_oe), .sdo_dev_i(sdo), .sdo_oe_i(sdo_oe), .bck_o(bck),
    .fs_o(fs), .sdi_o(sdi), .last_frame_o(frame), .last_len_o(flen),
    .frames_o(frames));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    wd <= wd + 1;
    if (wd == 60000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] resp);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] resp);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] resp;
    axw(a, v, resp);
    chk({30'h0, resp}, {30'h0, cdsi_pkg::RESP_OKAY});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] resp;
    axr(a, v, resp);
    chk(v, exp);
    chk({30'h0, resp}, {30'h0, cdsi_pkg::RESP_OKAY});
  endtask

  task automatic wait_frames(input int k);
    logic [15:0] f;
    f = frames + 16'(k);
    while (frames != f) @(posedge clk_sys_i);
  endtask

  initial begin
    reset_i = 1'b1;
    {awvalid, wvalid, arvalid, bready, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    run = 1'b0;
    sdrv = 1'b0;
    lvl = 1'b1;
    fbits = 9'h040;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rdchk(cdsi_pkg::CTRL1_OFS, 32'h0000_0000);
    rdchk(cdsi_pkg::CTRL2_OFS, 32'h0000_000F);
    rdchk(cdsi_pkg::CTRL3_OFS, 32'h0000_0000);
    axr(8'h30, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, cdsi_pkg::RESP_SLVERR});
    axw(8'h30, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, cdsi_pkg::RESP_SLVERR});
    wr(cdsi_pkg::TXBUF_OFS, 32'h1234_A50F);
    rdchk(cdsi_pkg::TXBUF_OFS, 32'h0000_A50F);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(cdsi_pkg::TXBUF_OFS + 8'(4 * i), {16'h0, 8'hA0 + 8'(i), 8'h5F});
    end
    wr(cdsi_pkg::CTRL2_OFS, 32'h0000_0037);
    wr(cdsi_pkg::CTRL3_OFS, 32'h0000_0004);
    for (int m = 0; m < 4; m++) begin
      wr(cdsi_pkg::CTRL1_OFS, 32'h0000_0000);
      wr(cdsi_pkg::CTRL1_OFS, {26'h0, 2'(m), 4'h1});
      wait_frames(4);
      chk({23'h0, flen}, m > 1 ? 32'h0000_0100 : 32'h0000_0020);
      if (m == 0) begin
        chk(frame, 32'hA0A1_A2A3);
        chk({31'h0, bck_oe}, 32'h0000_0001);
        chk({31'h0, fs_oe}, 32'h0000_0001);
        chk({31'h0, sdo_oe}, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
          rdchk(cdsi_pkg::RXBUF_OFS + 8'(4 * i), 32'h0000_FF00);
        end
      end
    end
    $display("test master modes done");
    wr(cdsi_pkg::CTRL1_OFS, 32'h0000_0000);
    chk({31'h0, fs_oe}, 32'h0000_0000);
    chk({31'h0, sdo_oe}, 32'h0000_0000);
    chk({31'h0, bck_oe}, 32'h0000_0001);
    rdchk(cdsi_pkg::STATUS_OFS, 32'h0000_0000);
    $display("test disable done");
    wr(cdsi_pkg::CTRL3_OFS, 32'h0000_0000);
    wr(cdsi_pkg::CTRL1_OFS, 32'h0000_000F);
    chk({31'h0, sdo_oe}, 32'h0000_0001);
    chk({31'h0, sdo}, 32'h0000_0000);
    wr(cdsi_pkg::CTRL1_OFS, 32'h0000_0000);
    $display("test idle drive done");
    sdrv <= 1'b1;
    run <= 1'b1;
    wr(cdsi_pkg::CTRL2_OFS, 32'h0000_003F);
    wr(cdsi_pkg::CTRL1_OFS, 32'h0000_000B);
    wait_frames(4);
    chk({31'h0, bck_oe}, 32'h0000_0000);
    chk({31'h0, fs_oe}, 32'h0000_0000);
    chk(frame, 32'hA25F_A35F);
    for (int i = 0; i < 4; i++) begin
      rdchk(cdsi_pkg::RXBUF_OFS + 8'(4 * i), 32'h0000_FFFF);
    end
    run <= 1'b0;
    $display("test slave done");
    finish_test();
  end
endmodule // codec_serial_interface_bench

// *** core/cdsi_core.sv ***
// Converter serial module: AXI4-Lite registers, pins and serial engine.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module cdsi_core (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic bit_clock_pin_i,
  output logic bit_clock_pin_o,
  output logic bit_clock_pin_oe_o,
  input wire logic frame_sync_pin_i,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe_o,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_o
);
  logic [5:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [11:0] bcg_q;
  logic [15:0] tx_map_q [0:3];
  logic [15:0] rx_map_q [0:3];
  logic [15:0] shadow_q [0:7];
  logic aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, wmask, rd_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q, rresp_d, wsel_idx;
  logic wr_do, wr_hit;
  logic module_en, ck_dir, idle_low, fs_dir;
  cdsi_pkg::cdsi_mode_e mode;
  logic aclink;
  logic [3:0] eff_ws, eff_fsg;
  logic [11:0] div_q;
  logic bclk_q, gen_on, gen_flip;
  logic [2:0] bck_s_q, fs_s_q, sdi_s_q;
  logic bck_in_q, fs_in_q, sdi_in_q, fs_prev_q;
  logic bit_tick;
  logic active_q;
  logic [3:0] wcnt_q, fcnt_q;
  logic [1:0] addr_q;
  logic [15:0] shift_q, rx_full, rx_just;
  logic word_end, frame_end, slave_sync, slave_start, fs_master;

  assign module_en = ctrl1_q[cdsi_pkg::EN_BIT];
  assign ck_dir = ctrl1_q[cdsi_pkg::CKDIR_BIT];
  assign idle_low = ctrl1_q[cdsi_pkg::IDLE_BIT];
  assign fs_dir = ctrl1_q[cdsi_pkg::FSDIR_BIT];
  assign mode = cdsi_pkg::cdsi_mode_e'(ctrl1_q[cdsi_pkg::FSM_LSB +: 2]);
  assign aclink = (mode == cdsi_pkg::CDSI_MODE_AC16) ||
                  (mode == cdsi_pkg::CDSI_MODE_AC20);
  // Slot length and frame length are fixed for AC-Link.
  assign eff_ws = aclink ? cdsi_pkg::WS_FULL
                         : ctrl2_q[cdsi_pkg::WS_LSB +: 4];
  assign eff_fsg = aclink ? cdsi_pkg::FSG_ACLINK
                          : ctrl2_q[cdsi_pkg::FSG_LSB +: 4];

  // AXI4-Lite write channel; address and data accepted in either order.
  assign s_axi_awready_o = ce_i && !aw_ok_q && !bvalid_q;
  assign s_axi_wready_o = ce_i && !w_ok_q && !bvalid_q;
  assign wr_do = aw_ok_q && w_ok_q && !bvalid_q;
  assign wsel_idx = awaddr_q[cdsi_pkg::BUF_IDX_LSB +: 2];
  assign wr_hit = (awaddr_q == cdsi_pkg::CTRL1_OFS) ||
                  (awaddr_q == cdsi_pkg::CTRL2_OFS) ||
                  (awaddr_q == cdsi_pkg::CTRL3_OFS) ||
                  (awaddr_q[7:cdsi_pkg::BUF_SEL_LSB] ==
                   cdsi_pkg::TXBUF_OFS[7:cdsi_pkg::BUF_SEL_LSB]);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cdsi_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ok_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ok_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? cdsi_pkg::RESP_OKAY : cdsi_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control registers and the software side of the transmit buffer.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl1_q <= cdsi_pkg::CTRL1_RST;
      ctrl2_q <= cdsi_pkg::CTRL2_RST;
      bcg_q <= cdsi_pkg::BCG_RST;
      for (int i = 0; i < cdsi_pkg::BUF_WORDS; i++) begin
        tx_map_q[i] <= '0;
      end
    end else if (ce_i && wr_do) begin
      if (awaddr_q == cdsi_pkg::CTRL1_OFS) begin
        ctrl1_q <= (ctrl1_q & ~wmask[5:0]) | (wdata_q[5:0] & wmask[5:0]);
      end
      if (awaddr_q == cdsi_pkg::CTRL2_OFS) begin
        ctrl2_q <= (ctrl2_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
      end
      if (awaddr_q == cdsi_pkg::CTRL3_OFS) begin
        bcg_q <= (bcg_q & ~wmask[11:0]) | (wdata_q[11:0] & wmask[11:0]);
      end
      if (awaddr_q[7:cdsi_pkg::BUF_SEL_LSB] ==
          cdsi_pkg::TXBUF_OFS[7:cdsi_pkg::BUF_SEL_LSB]) begin
        tx_map_q[wsel_idx] <= (tx_map_q[wsel_idx] & ~wmask[15:0]) |
                              (wdata_q[15:0] & wmask[15:0]);
      end
    end
  end

  // AXI4-Lite read channel; answer one cycle after the address.
  assign s_axi_arready_o = ce_i && !rvalid_q;

  always_comb begin
    rd_d = '0;
    rresp_d = cdsi_pkg::RESP_OKAY;
    if (s_axi_araddr_i == cdsi_pkg::CTRL1_OFS) begin
      rd_d[5:0] = ctrl1_q;
    end else if (s_axi_araddr_i == cdsi_pkg::CTRL2_OFS) begin
      rd_d[7:0] = ctrl2_q;
    end else if (s_axi_araddr_i == cdsi_pkg::CTRL3_OFS) begin
      rd_d[11:0] = bcg_q;
    end else if (s_axi_araddr_i == cdsi_pkg::STATUS_OFS) begin
      rd_d[10:0] = {active_q, fcnt_q, wcnt_q, addr_q};
    end else if (s_axi_araddr_i[7:cdsi_pkg::BUF_SEL_LSB] ==
                 cdsi_pkg::RXBUF_OFS[7:cdsi_pkg::BUF_SEL_LSB]) begin
      rd_d[15:0] = rx_map_q[s_axi_araddr_i[cdsi_pkg::BUF_IDX_LSB +: 2]];
    end else if (s_axi_araddr_i[7:cdsi_pkg::BUF_SEL_LSB] ==
                 cdsi_pkg::TXBUF_OFS[7:cdsi_pkg::BUF_SEL_LSB]) begin
      rd_d[15:0] = tx_map_q[s_axi_araddr_i[cdsi_pkg::BUF_IDX_LSB +: 2]];
    end else begin
      rresp_d = cdsi_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= cdsi_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_d;
        rresp_q <= rresp_d;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // Bit clock generator runs when its divisor is non-zero and the bit clock is an output (ck_dir low), enable or not.
  assign gen_on = (bcg_q != cdsi_pkg::BCG_RST) && !ck_dir;
  assign gen_flip = gen_on && (div_q == bcg_q);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !gen_on) begin
      div_q <= '0;
      bclk_q <= 1'b0;
    end else if (ce_i) begin
      div_q <= gen_flip ? '0 : div_q + 12'h001;
      if (gen_flip) begin
        bclk_q <= !bclk_q;
      end
    end
  end

  // Pin inputs: three stages, a change counts once stages two and three agree.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bck_s_q <= '0;
      fs_s_q <= '0;
      sdi_s_q <= '0;
      bck_in_q <= 1'b0;
      fs_in_q <= 1'b0;
      sdi_in_q <= 1'b0;
    end else if (ce_i) begin
      bck_s_q <= {bck_s_q[1:0], bit_clock_pin_i};
      fs_s_q <= {fs_s_q[1:0], frame_sync_pin_i};
      sdi_s_q <= {sdi_s_q[1:0], serial_data_in_pin_i};
      if (bck_s_q[1] == bck_s_q[2]) begin
        bck_in_q <= bck_s_q[2];
      end
      if (fs_s_q[1] == fs_s_q[2]) begin
        fs_in_q <= fs_s_q[2];
      end
      if (sdi_s_q[1] == sdi_s_q[2]) begin
        sdi_in_q <= sdi_s_q[2];
      end
    end
  end

  // One tick per falling bit clock edge, only while enabled.
  assign bit_tick = ce_i && module_en &&
                    (ck_dir ? (bck_in_q && (bck_s_q[1] == bck_s_q[2]) &&
                               !bck_s_q[2])
                            : (gen_flip && bclk_q));

  assign word_end = active_q && (wcnt_q == eff_ws);
  assign frame_end = word_end && (fcnt_q == eff_fsg);
  // A sync seen on the last step of a frame chains the next frame directly.
  assign slave_sync = (mode == cdsi_pkg::CDSI_MODE_I2S) ?
                      (fs_in_q != fs_prev_q) : fs_in_q;
  assign slave_start = fs_dir && !active_q && slave_sync;
  assign rx_full = {shift_q[14:0], sdi_in_q};
  assign rx_just = rx_full << (cdsi_pkg::WS_FULL - eff_ws);

  // Serial engine: counters, shift register and shadow buffers.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (ce_i && !module_en)) begin
      active_q <= 1'b0;
      wcnt_q <= '0;
      fcnt_q <= '0;
      addr_q <= '0;
      shift_q <= '0;
      fs_prev_q <= 1'b0;
    end else if (bit_tick) begin
      fs_prev_q <= fs_in_q;
      if (!active_q) begin
        if (!fs_dir || slave_start) begin
          active_q <= 1'b1;
          wcnt_q <= '0;
          fcnt_q <= '0;
          shift_q <= shadow_q[{1'b1, addr_q}];
        end
      end else if (word_end) begin
        wcnt_q <= '0;
        fcnt_q <= frame_end ? '0 : fcnt_q + 4'h1;
        addr_q <= addr_q + 2'h1;
        shift_q <= (addr_q == cdsi_pkg::ADDR_LAST) ? tx_map_q[0]
                   : shadow_q[{1'b1, addr_q + 2'h1}];
        if (frame_end && fs_dir && !slave_sync) begin
          active_q <= 1'b0;
        end
      end else begin
        wcnt_q <= wcnt_q + 4'h1;
        shift_q <= rx_full;
      end
    end
  end

  // Shadow buffers swap with the mapped buffers once every four words.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2 * cdsi_pkg::BUF_WORDS; i++) begin
        shadow_q[i] <= '0;
      end
      for (int i = 0; i < cdsi_pkg::BUF_WORDS; i++) begin
        rx_map_q[i] <= '0;
      end
    end else if (bit_tick && word_end) begin
      shadow_q[{1'b0, addr_q}] <= rx_just;
      if (addr_q == cdsi_pkg::ADDR_LAST) begin
        for (int i = 0; i < cdsi_pkg::BUF_WORDS - 1; i++) begin
          rx_map_q[i] <= shadow_q[i];
        end
        rx_map_q[cdsi_pkg::BUF_WORDS - 1] <= rx_just;
        for (int i = 0; i < cdsi_pkg::BUF_WORDS; i++) begin
          shadow_q[cdsi_pkg::BUF_WORDS + i] <= tx_map_q[i];
        end
      end
    end
  end

  // Master frame sync shapes per mode.
  always_comb begin
    case (mode)
      cdsi_pkg::CDSI_MODE_MULTI: fs_master = active_q && (fcnt_q == '0) &&
                                             (wcnt_q == '0);
      cdsi_pkg::CDSI_MODE_I2S: fs_master = active_q &&
                                           (fcnt_q > (eff_fsg >> 1));
      cdsi_pkg::CDSI_MODE_AC16,
      cdsi_pkg::CDSI_MODE_AC20: fs_master = active_q && (fcnt_q == '0);
      default: fs_master = 1'b0;
    endcase
  end

  // Pin ownership while enabled; the bit clock may be owned on its own.
  assign bit_clock_pin_o = bclk_q;
  assign bit_clock_pin_oe_o = gen_on && (module_en || !ck_dir);
  assign frame_sync_pin_o = fs_master;
  assign frame_sync_pin_oe_o = module_en && !fs_dir;
  assign serial_data_out_pin_o = active_q && shift_q[15];
  assign serial_data_out_pin_oe_o = module_en && (active_q || idle_low);

  sequence s_word_done;
    bit_tick && word_end;
  endsequence

  AST_ADDR_WRAP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_word_done and (addr_q == cdsi_pkg::ADDR_LAST) |=> addr_q == 2'h0)
    else $error("address counter did not wrap");
  AST_ADDR_STEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_word_done |=> addr_q == $past(addr_q) + 2'h1)
    else $error("address counter did not step");
  AST_DISABLE_CLR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ce_i && !module_en |=> addr_q == 2'h0 && wcnt_q == 4'h0 && !active_q)
    else $error("disable did not reset counters");
  AST_NO_TICK_OFF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !module_en |-> !bit_tick)
    else $error("engine ticked while disabled");
  AST_BCK_DIR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ck_dir |-> !bit_clock_pin_oe_o)
    else $error("bit clock driven while set as input");
  AST_FS_DIR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    frame_sync_pin_oe_o == (module_en && !fs_dir))
    else $error("frame sync direction wrong");
  AST_SDO_IDLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    module_en && !active_q |-> (serial_data_out_pin_oe_o == idle_low) &&
    !serial_data_out_pin_o)
    else $error("idle data out level wrong");
  AST_RX_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_word_done |=> (shadow_q[{1'b0, $past(addr_q)}] &
                    (16'hffff >> ({1'b0, $past(eff_ws)} + 5'h01))) ==
                    16'h0000)
    else $error("receive low bits not zero");
  AST_FRAME_STEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_word_done and !frame_end |=> fcnt_q == $past(fcnt_q) + 4'h1)
    else $error("frame counter did not advance");
  AST_ACLINK_FIX: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    aclink |-> eff_ws == cdsi_pkg::WS_FULL && eff_fsg == cdsi_pkg::FSG_ACLINK)
    else $error("AC-Link frame not fixed");
  AST_SLAVE_CHAIN: assert property (@(posedge clk_sys_i)
    disable iff (reset_i)
    s_word_done and (frame_end && fs_dir && slave_sync) |=> active_q)
    else $error("slave missed a back to back frame sync");
endmodule // cdsi_core

// *** shared/cdsi_pkg.sv ***
// Constants shared by the converter serial module.
package cdsi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int BUF_WORDS = 4;
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] CTRL2_OFS = 8'h04;
  localparam logic [7:0] CTRL3_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RXBUF_OFS = 8'h10;
  localparam logic [7:0] TXBUF_OFS = 8'h20;
  localparam int BUF_SEL_LSB = 4;
  localparam int BUF_IDX_LSB = 2;
  localparam int EN_BIT = 0;
  localparam int CKDIR_BIT = 1;
  localparam int IDLE_BIT = 2;
  localparam int FSDIR_BIT = 3;
  localparam int FSM_LSB = 4;
  localparam int CTRL1_W = 6;
  localparam int WS_LSB = 0;
  localparam int FSG_LSB = 4;
  localparam int CTRL2_W = 8;
  localparam int BCG_W = 12;
  localparam logic [5:0] CTRL1_RST = 6'h00;
  localparam logic [7:0] CTRL2_RST = 8'h0f;
  localparam logic [11:0] BCG_RST = 12'h000;
  localparam logic [3:0] WS_FULL = 4'hf;
  localparam logic [3:0] FSG_ACLINK = 4'hf;
  localparam logic [1:0] ADDR_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CDSI_MODE_MULTI = 2'b00,
    CDSI_MODE_I2S = 2'b01,
    CDSI_MODE_AC16 = 2'b10,
    CDSI_MODE_AC20 = 2'b11
  } cdsi_mode_e;
endpackage
